// File: design/fms_status_flags.sv
// Status and control flag bank of a sensor-actuator bus master.
`timescale 1ns/1ps
`include "fms_defines.svh"

// Behaviour
// - Config byte 0: identification low, I/O high.
// - Config byte 1: extended code 2 low, 1 high.
// - Diagnosis reply carries execution flags in professional mode.
// - Execution byte 0 bits report master state.
// - Newer master adds periphery-ok byte, rest zero.
// - Host flag bit 0 enables cyclic data exchange.
// - Host flag bit 1 forces offline phase.
// - Host flag bit 2 disables auto addressing, persistent.
// - Version read with 4 returns 17 bytes.
// - Char 0 case shows controller program running.
// - Char 1 shows multidrop serial command support.
// - Chars 2-5 show optional feature support.
// - Char 6 shows one or two circuits.
// - Chars 8-10 echo the host flags.
// - Char 12 shows newer master specification.
// - Char 14 shows serial watchdog state.
// - Char 15 shows front panel enable.
// - Start flag runs program when state allows; persistent.
// - Reset bit reloads program, clears memory; unread.
// - Ignore flag clear stops program on config error.
// - Auto start flag waits for set button.
// - Counter map flag maps counters into memory.
// - Input data two slaves per byte, low first.
module fms_status_flags #(
   parameter fms_pkg::fms_caps_s CAPS = 8'hFF
) (
   // Clock and reset.
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // Host message port.
   input  wire logic              cmd_valid_in,
   input  wire logic [7:0]        cmd_code_in,
   input  wire logic [7:0]        cmd_data_in,
   // Reply byte stream.
   output logic                   rsp_valid_out,
   output logic [7:0]             rsp_data_out,
   output logic                   rsp_last_out,
   output logic                   busy_out,
   output logic                   cmd_error_out,
   // Master state and buttons.
   input  wire fms_pkg::fms_stat_s stat_in,
   input  wire logic              set_button_in,
   // Slave configuration and input data.
   input  wire logic              cfg_we_in,
   input  wire logic [5:0]        cfg_addr_in,
   input  wire fms_pkg::fms_cfg_s cfg_data_in,
   input  wire logic [255:0]      in_data_in,
   // Non-volatile flag image.
   input  wire logic              nv_restore_in,
   input  wire fms_pkg::fms_host_s nv_host_in,
   input  wire fms_pkg::fms_ctrl_s nv_ctrl_in,
   output logic                   nv_store_out,
   output fms_pkg::fms_host_s     nv_host_out,
   output fms_pkg::fms_ctrl_s     nv_ctrl_out,
   // Control outputs.
   output logic                   data_exchange_out,
   output logic                   force_offline_out,
   output logic                   auto_addr_disable_out,
   output logic                   prog_run_out,
   output logic                   prog_reload_out,
   output logic                   user_mem_clear_out,
   output logic                   counter_map_out
);
   import fms_pkg::*;

   // ****************
   // State and storage
   // ****************
   fms_regs_s   st_ff;
   fms_regs_s   nxt_st;
   fms_cfg_s    cfg_mem_ff [0:63];
   fms_cfg_s    cfg_rd;
   logic [7:0]  ver_char;
   logic [7:0]  reply_byte;
   logic [7:0]  exec_lo;
   logic [7:0]  exec_hi;
   logic        allowed;
   logic [5:0]  req_last;
   logic        req_ok;

   // Reads the stored controller flags; the reload bit always reads zero.
   function automatic logic [7:0] ctrl_byte(input fms_ctrl_s c);
      ctrl_byte = {3'h0, c.counter_map, c.auto_start, c.ignore_cfg, 1'b0, c.start};
   endfunction

   // Reads the stored host flags with the unused upper bits at zero.
   function automatic logic [7:0] host_byte(input fms_host_s h);
      host_byte = {5'h00, h.auto_addr_off, h.offline, h.data_exchange};
   endfunction

   // ****************
   // Slave configuration memory
   // ****************
   // The bus side writes each slave's configuration as it is read in.
   always_ff @(posedge clk_in) begin
      if (cfg_we_in) begin
         cfg_mem_ff[cfg_addr_in] <= cfg_data_in;
      end
   end

   // Configuration entry addressed by the current message.
   assign cfg_rd = cfg_mem_ff[st_ff.arg];

   // ****************
   // Execution flags and run permission
   // ****************
   // Execution byte 0, one bit per master state, active high.
   assign exec_lo = {stat_in.offline_active, stat_in.bus_power_fail, stat_in.normal_op,
                     stat_in.config_mode, stat_in.auto_addr_avail, stat_in.auto_addr_permit,
                     stat_in.slave_zero_present, stat_in.config_ok};

   // Execution byte 1 carries only the periphery flag on a newer master.
   assign exec_hi = {7'h00, CAPS.newer_spec & stat_in.periphery_ok};

   // The program may run when the master allows and no blocking config error.
   assign allowed = stat_in.master_run_ok & (st_ff.ctrl.ignore_cfg | stat_in.config_ok);

   // ****************
   // Version string
   // ****************
   fms_version_char u_version_char (
      .idx_in      (st_ff.idx[4:0]),
      .prog_run_in (st_ff.prog == FMS_PRG_RUN),
      .host_in     (st_ff.host),
      .stat_in     (stat_in),
      .caps_in     (CAPS),
      .char_out    (ver_char)
   );

   // ****************
   // Message decode
   // ****************
   // Checks a new message and works out the index of its last reply byte.
   always_comb begin
      req_ok   = 1'b1;
      req_last = `FMS_LAST_SINGLE;
      case (cmd_code_in)
         `FMS_CMD_RD_VERSION: begin
            req_ok   = (cmd_data_in == `FMS_VERSION_SELECT);
            req_last = `FMS_LAST_VERSION;
         end
         `FMS_CMD_RD_INPUT: begin
            req_last = CAPS.newer_spec ? `FMS_LAST_INPUT_NEW : `FMS_LAST_INPUT_OLD;
         end
         `FMS_CMD_RD_CFG: begin
            req_ok   = CAPS.newer_spec | ~cmd_data_in[5];
            req_last = CAPS.newer_spec ? `FMS_LAST_PAIR : `FMS_LAST_SINGLE;
         end
         `FMS_CMD_RD_DIAG: begin
            if (stat_in.professional_mode) begin
               req_last = CAPS.newer_spec ? `FMS_LAST_TRIPLE : `FMS_LAST_PAIR;
            end
         end
         `FMS_CMD_RD_HOST, `FMS_CMD_WR_HOST, `FMS_CMD_RD_CTRL, `FMS_CMD_WR_CTRL: begin
            req_last = `FMS_LAST_SINGLE;
         end
         default: begin
            req_ok = 1'b0;
         end
      endcase
   end

   // ****************
   // Reply byte selection
   // ****************
   // Picks the byte at the current reply index for the message in progress.
   always_comb begin
      case (st_ff.cmd)
         `FMS_CMD_RD_VERSION: begin
            reply_byte = ver_char;
         end
         `FMS_CMD_RD_INPUT: begin
            reply_byte = in_data_in[{st_ff.idx[4:0], 3'h0} +: 8];
         end
         `FMS_CMD_RD_CFG: begin
            reply_byte = (st_ff.idx == 6'h00) ? {cfg_rd.io_code, cfg_rd.id_code}
                                              : {cfg_rd.ext_id1, cfg_rd.ext_id2};
         end
         `FMS_CMD_RD_DIAG: begin
            case (st_ff.idx[1:0])
               2'h0:    reply_byte = host_byte(st_ff.host);
               2'h1:    reply_byte = exec_lo;
               default: reply_byte = exec_hi;
            endcase
         end
         `FMS_CMD_RD_HOST, `FMS_CMD_WR_HOST: begin
            reply_byte = host_byte(st_ff.host);
         end
         `FMS_CMD_RD_CTRL, `FMS_CMD_WR_CTRL: begin
            reply_byte = ctrl_byte(st_ff.ctrl);
         end
         default: begin
            reply_byte = 8'h00;
         end
      endcase
   end

   // ****************
   // Next state
   // ****************
   // Runs the message sequencer, the flag writes and the program state.
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.rsp_valid = 1'b0;
      nxt_st.rsp_last  = 1'b0;
      nxt_st.err       = 1'b0;
      nxt_st.nv_store  = 1'b0;
      nxt_st.reload    = 1'b0;
      nxt_st.mem_clear = 1'b0;

      // Power-up restore of the persistent flags.
      if (nv_restore_in) begin
         nxt_st.host.auto_addr_off = nv_host_in.auto_addr_off;
         nxt_st.ctrl               = nv_ctrl_in;
      end

      // Message sequencer: accept in idle, then stream one byte a cycle.
      case (st_ff.phase)
         FMS_IDLE: begin
            if (cmd_valid_in) begin
               if (req_ok) begin
                  nxt_st.phase = FMS_REPLY;
                  nxt_st.cmd   = cmd_code_in;
                  nxt_st.arg   = cmd_data_in[5:0];
                  nxt_st.idx   = 6'h00;
                  nxt_st.last  = req_last;
                  if (cmd_code_in == `FMS_CMD_WR_HOST) begin
                     nxt_st.host.data_exchange = cmd_data_in[`FMS_HOST_DX_BIT];
                     nxt_st.host.offline       = cmd_data_in[`FMS_HOST_OFFL_BIT];
                     nxt_st.host.auto_addr_off = cmd_data_in[`FMS_HOST_AAD_BIT];
                     nxt_st.nv_store           = 1'b1;
                  end
                  if (cmd_code_in == `FMS_CMD_WR_CTRL) begin
                     nxt_st.ctrl.start       = cmd_data_in[`FMS_CTRL_START_BIT];
                     nxt_st.ctrl.ignore_cfg  = cmd_data_in[`FMS_CTRL_IGN_BIT];
                     nxt_st.ctrl.auto_start  = cmd_data_in[`FMS_CTRL_AUTO_BIT];
                     nxt_st.ctrl.counter_map = cmd_data_in[`FMS_CTRL_CMAP_BIT];
                     nxt_st.nv_store         = 1'b1;
                  end
               end else begin
                  nxt_st.err = 1'b1;
               end
            end
         end
         FMS_REPLY: begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_data  = reply_byte;
            nxt_st.rsp_last  = (st_ff.idx == st_ff.last);
            if (st_ff.idx == st_ff.last) begin
               nxt_st.phase = FMS_IDLE;
            end else begin
               nxt_st.idx = st_ff.idx + 6'h01;
            end
            if (cmd_valid_in) begin
               nxt_st.err = 1'b1;
            end
         end
         default: begin
            nxt_st.phase = FMS_IDLE;
         end
      endcase

      // Controller program state.
      case (st_ff.prog)
         FMS_PRG_STOP: begin
            if (st_ff.ctrl.start && allowed) begin
               nxt_st.prog = st_ff.ctrl.auto_start ? FMS_PRG_WAIT : FMS_PRG_RUN;
            end
         end
         FMS_PRG_RELOAD: begin
            nxt_st.prog = FMS_PRG_STOP;
         end
         FMS_PRG_WAIT: begin
            if (!st_ff.ctrl.start || !allowed) begin
               nxt_st.prog = FMS_PRG_STOP;
            end else if (set_button_in) begin
               nxt_st.prog = FMS_PRG_RUN;
            end
         end
         FMS_PRG_RUN: begin
            if (!st_ff.ctrl.start || !allowed) begin
               nxt_st.prog = FMS_PRG_STOP;
            end
         end
         default: begin
            nxt_st.prog = FMS_PRG_STOP;
         end
      endcase

      // A reset bit write reloads the program and clears user memory first.
      if (st_ff.phase == FMS_IDLE && cmd_valid_in && req_ok &&
          cmd_code_in == `FMS_CMD_WR_CTRL && cmd_data_in[`FMS_CTRL_RESET_BIT]) begin
         nxt_st.prog      = FMS_PRG_RELOAD;
         nxt_st.reload    = 1'b1;
         nxt_st.mem_clear = 1'b1;
      end
   end

   // ****************
   // State register
   // ****************
   // Registers the whole state; everything clears on reset.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_ff       <= '0;
         st_ff.phase <= FMS_IDLE;
         st_ff.prog  <= FMS_PRG_STOP;
         st_ff.host  <= `FMS_HOST_RESET;
         st_ff.ctrl  <= `FMS_CTRL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************
   // Outputs
   // ****************
   // Every output is a field of the state register; busy_out and prog_run_out are decoded from one.
   assign rsp_valid_out         = st_ff.rsp_valid;
   assign rsp_data_out          = st_ff.rsp_data;
   assign rsp_last_out          = st_ff.rsp_last;
   assign busy_out              = (st_ff.phase == FMS_REPLY);
   assign cmd_error_out         = st_ff.err;
   assign nv_store_out          = st_ff.nv_store;
   assign nv_host_out           = st_ff.host;
   assign nv_ctrl_out           = st_ff.ctrl;
   assign data_exchange_out     = st_ff.host.data_exchange;
   assign force_offline_out     = st_ff.host.offline;
   assign auto_addr_disable_out = st_ff.host.auto_addr_off;
   assign prog_run_out          = (st_ff.prog == FMS_PRG_RUN);
   assign prog_reload_out       = st_ff.reload;
   assign user_mem_clear_out    = st_ff.mem_clear;
   assign counter_map_out       = st_ff.ctrl.counter_map;

endmodule // fms_status_flags

// File: design/fms_defines.svh
// Constant macros for the fieldbus master status flag bank.
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH

// ****************
// Host message codes
// ****************
`define FMS_CMD_RD_VERSION   8'h7D
`define FMS_VERSION_SELECT   8'h04
`define FMS_CMD_RD_INPUT     8'h71
`define FMS_CMD_RD_HOST      8'h61
`define FMS_CMD_WR_HOST      8'h62
`define FMS_CMD_RD_CTRL      8'h63
`define FMS_CMD_WR_CTRL      8'h64
`define FMS_CMD_RD_CFG       8'h65
`define FMS_CMD_RD_DIAG      8'h66

// ****************
// Reply lengths, written as index of the last byte
// ****************
`define FMS_LAST_VERSION     6'h10
`define FMS_LAST_INPUT_OLD   6'h0F
`define FMS_LAST_INPUT_NEW   6'h1F
`define FMS_LAST_SINGLE      6'h00
`define FMS_LAST_PAIR        6'h01
`define FMS_LAST_TRIPLE      6'h02

// ****************
// Field positions of written flag bytes
// ****************
`define FMS_HOST_DX_BIT      0
`define FMS_HOST_OFFL_BIT    1
`define FMS_HOST_AAD_BIT     2
`define FMS_CTRL_START_BIT   0
`define FMS_CTRL_RESET_BIT   1
`define FMS_CTRL_IGN_BIT     2
`define FMS_CTRL_AUTO_BIT    3
`define FMS_CTRL_CMAP_BIT    4

// ****************
// Reset values and neutral characters
// ****************
`define FMS_HOST_RESET       3'h0
`define FMS_CTRL_RESET       4'h0
`define FMS_CHAR_UNUSED      8'h20
`define FMS_CHAR_NULL        8'h00
`define FMS_CHAR_PERIOD      8'h2E
`define FMS_CHAR_TWO         8'h32
`define FMS_CASE_LOWER       8'h20

`endif

// File: design/fms_pkg.sv
// Types shared by the fieldbus master status flag bank.
package fms_pkg;

   // Reply sequencer phase.
   typedef enum logic [0:0] {
      FMS_IDLE  = 1'b0,
      FMS_REPLY = 1'b1
   } fms_phase_e;

   // Controller program run state.
   typedef enum logic [1:0] {
      FMS_PRG_STOP   = 2'b00,
      FMS_PRG_RELOAD = 2'b01,
      FMS_PRG_WAIT   = 2'b10,
      FMS_PRG_RUN    = 2'b11
   } fms_prog_e;

   // Slave configuration data, byte 1 above byte 0.
   typedef struct packed {
      logic [3:0] ext_id1;
      logic [3:0] ext_id2;
      logic [3:0] io_code;
      logic [3:0] id_code;
   } fms_cfg_s;

   // Live master status seen by the flag bank.
   typedef struct packed {
      logic config_ok;
      logic slave_zero_present;
      logic auto_addr_permit;
      logic auto_addr_avail;
      logic config_mode;
      logic normal_op;
      logic bus_power_fail;
      logic offline_active;
      logic periphery_ok;
      logic professional_mode;
      logic master_run_ok;
      logic watchdog_active;
      logic panel_enabled;
   } fms_stat_s;

   // Stored host interface flags.
   typedef struct packed {
      logic auto_addr_off;
      logic offline;
      logic data_exchange;
   } fms_host_s;

   // Stored controller flags; the reload bit is never stored.
   typedef struct packed {
      logic counter_map;
      logic auto_start;
      logic ignore_cfg;
      logic start;
   } fms_ctrl_s;

   // Fixed capabilities of this master.
   typedef struct packed {
      logic newer_spec;
      logic newer_ctrl;
      logic multidrop;
      logic err_counters;
      logic emc_test;
      logic adv_diag;
      logic offline_on_cfg;
      logic two_circuits;
   } fms_caps_s;

   // Whole register state of the flag bank.
   typedef struct packed {
      fms_phase_e phase;
      logic [7:0] cmd;
      logic [5:0] arg;
      logic [5:0] idx;
      logic [5:0] last;
      fms_host_s  host;
      fms_ctrl_s  ctrl;
      fms_prog_e  prog;
      logic       rsp_valid;
      logic [7:0] rsp_data;
      logic       rsp_last;
      logic       err;
      logic       nv_store;
      logic       reload;
      logic       mem_clear;
   } fms_regs_s;

endpackage

// File: design/fms_version_char.sv
// Character generator for the 17-byte version and capability string.
`timescale 1ns/1ps
`include "fms_defines.svh"

module fms_version_char (
   // Character position.
   input  wire logic [4:0]        idx_in,
   // Inputs reported by the string.
   input  wire logic              prog_run_in,
   input  wire fms_pkg::fms_host_s host_in,
   input  wire fms_pkg::fms_stat_s stat_in,
   input  wire fms_pkg::fms_caps_s caps_in,
   // Character at the position.
   output logic [7:0]             char_out
);
   import fms_pkg::*;

   // Upper case letter when set, lower case when clear.
   function automatic logic [7:0] by_case(input logic [7:0] upper, input logic set);
      by_case = set ? upper : (upper | `FMS_CASE_LOWER);
   endfunction

   // Select the character for each position; unused ones stay neutral.
   always_comb begin
      case (idx_in)
         5'h00: char_out = by_case(caps_in.newer_ctrl ? 8'h44 : 8'h43, prog_run_in);
         5'h01: char_out = by_case(8'h42, caps_in.multidrop);
         5'h02: char_out = by_case(8'h46, caps_in.err_counters);
         5'h03: char_out = by_case(8'h45, caps_in.emc_test);
         5'h04: char_out = by_case(8'h44, caps_in.adv_diag);
         5'h05: char_out = by_case(8'h43, caps_in.offline_on_cfg);
         5'h06: char_out = caps_in.two_circuits ? `FMS_CHAR_TWO : `FMS_CHAR_PERIOD;
         5'h08: char_out = by_case(8'h44, host_in.data_exchange);
         5'h09: char_out = by_case(8'h4F, host_in.offline);
         5'h0A: char_out = by_case(8'h41, host_in.auto_addr_off);
         5'h0C: char_out = caps_in.newer_spec ? 8'h41 : `FMS_CHAR_PERIOD;
         5'h0E: char_out = by_case(8'h57, stat_in.watchdog_active);
         5'h0F: char_out = by_case(8'h54, stat_in.panel_enabled);
         5'h10: char_out = `FMS_CHAR_NULL;
         default: char_out = `FMS_CHAR_UNUSED;
      endcase
   end

endmodule // fms_version_char

// File: dv/fms_status_flags_assertions.sv
// Concurrent checks on the ports of the fieldbus master status flag bank.
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_chk (
   // Clock, reset and host message port.
   input wire logic               clk_in,
   input wire logic               rst_in,
   input wire logic               cmd_valid_in,
   input wire logic [7:0]         cmd_code_in,
   input wire logic [7:0]         cmd_data_in,
   // Reply stream.
   input wire logic               rsp_valid_out,
   input wire logic [7:0]         rsp_data_out,
   input wire logic               rsp_last_out,
   input wire logic               busy_out,
   input wire logic               cmd_error_out,
   // Flags and program state.
   input wire fms_pkg::fms_stat_s stat_in,
   input wire fms_pkg::fms_ctrl_s nv_ctrl_out,
   input wire logic               nv_store_out,
   input wire logic               data_exchange_out,
   input wire logic               prog_run_out,
   input wire logic               prog_reload_out,
   input wire logic               user_mem_clear_out
);
   import fms_pkg::*;
   logic acc;
   logic wr_host;
   // A message counts as taken only while the bank is idle.
   assign acc     = cmd_valid_in && !busy_out;
   assign wr_host = acc && cmd_code_in == `FMS_CMD_WR_HOST;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ****************
   // Reply framing, flag effects and program state
   // ****************
   a_version_length: assert property (
      acc && cmd_code_in == `FMS_CMD_RD_VERSION && cmd_data_in == `FMS_VERSION_SELECT |->
      ##2 (rsp_valid_out && !rsp_last_out)[*8] ##1 (rsp_valid_out && !rsp_last_out)[*8]
      ##1 (rsp_valid_out && rsp_last_out && rsp_data_out == `FMS_CHAR_NULL))
      else $error("version reply has wrong length or end");
   a_bad_select: assert property (
      acc && cmd_code_in == `FMS_CMD_RD_VERSION && cmd_data_in != `FMS_VERSION_SELECT
      |=> cmd_error_out ##1 !rsp_valid_out) else $error("bad version select not refused");
   a_last_ends: assert property (
      rsp_last_out |-> rsp_valid_out && !busy_out) else $error("last byte framing wrong");
   a_host_apply: assert property (
      wr_host |=> nv_store_out ##1 data_exchange_out == $past(cmd_data_in[0], 2))
      else $error("host flag write not applied");
   a_exchange_cause: assert property (
      $changed(data_exchange_out) |-> $past(wr_host)) else $error("exchange flag moved alone");
   a_reload_pulse: assert property (
      acc && cmd_code_in == `FMS_CMD_WR_CTRL && cmd_data_in[1] |=> prog_reload_out
      && user_mem_clear_out ##1 !(prog_reload_out || user_mem_clear_out))
      else $error("reload pulse wrong");
   a_run_drops: assert property (
      (!stat_in.master_run_ok)[*3] |-> !prog_run_out) else $error("program runs when barred");
   a_cfg_err_stop: assert property (
      (!nv_ctrl_out.ignore_cfg && !stat_in.config_ok)[*3] |-> !prog_run_out)
      else $error("program runs on configuration error");
endmodule // fms_chk

bind fms_status_flags fms_chk u_chk (.clk_in, .rst_in, .cmd_valid_in, .cmd_code_in,
   .cmd_data_in, .rsp_valid_out, .rsp_data_out, .rsp_last_out, .busy_out, .cmd_error_out,
   .stat_in, .nv_ctrl_out, .nv_store_out, .data_exchange_out, .prog_run_out, .prog_reload_out,
   .user_mem_clear_out);

// File: dv/fms_host_model.sv
// Host computer model that sends messages and gathers reply bytes.
`timescale 1ns/1ps
module fms_host_model (
   // Clock and reply stream.
   input  wire logic       clk_in,
   input  wire logic       rsp_valid_out,
   input  wire logic [7:0] rsp_data_out,
   input  wire logic       busy_out,
   // Host message port.
   output logic            cmd_valid_in,
   output logic [7:0]      cmd_code_in,
   output logic [7:0]      cmd_data_in
);
   logic [7:0] rx_q[$];
   // The port starts quiet.
   initial begin
      cmd_valid_in = 1'b0;
      cmd_code_in  = 8'h00;
      cmd_data_in  = 8'h00;
   end
   // Every reply byte is kept in order of arrival.
   always @(negedge clk_in) begin
      if (rsp_valid_out === 1'b1) rx_q.push_back(rsp_data_out);
   end
   // One message stands for one cycle while idle; lines then show the inverse.
   task automatic send(input logic [7:0] code, input logic [7:0] data);
      @(negedge clk_in);
      while (busy_out !== 1'b0) @(negedge clk_in);
      cmd_valid_in = 1'b1;
      cmd_code_in  = code;
      cmd_data_in  = data;
      @(negedge clk_in);
      cmd_valid_in = 1'b0;
      cmd_code_in  = ~code;
      cmd_data_in  = ~data;
   endtask
endmodule // fms_host_model

// File: dv/fms_tb.sv
// Self-checking testbench of the fieldbus master status flag bank.
`timescale 1ns/1ps
`include "fms_defines.svh"
module testbench;
   import fms_pkg::*;
   logic         clk_in, rst_in, set_button_in, cfg_we_in, nv_restore_in, run;
   logic         cmd_valid_in, rsp_valid_out, rsp_last_out, busy_out, prog_run_out;
   logic         data_exchange_out, force_offline_out, auto_addr_disable_out, counter_map_out;
   logic [7:0]   cmd_code_in, cmd_data_in, rsp_data_out, h, c, e;
   logic [5:0]   cfg_addr_in;
   logic [255:0] in_data_in;
   fms_stat_s    stat_in;
   fms_cfg_s     cfg_data_in;
   fms_host_s    nv_host_in, nv_host_out;
   fms_ctrl_s    nv_ctrl_in, nv_ctrl_out;
   logic [7:0]   exp_q[$];
   int           fail_count, check_count, seed, n, k;
   fms_status_flags DUT (.clk_in, .rst_in, .cmd_valid_in, .cmd_code_in, .cmd_data_in,
      .rsp_valid_out, .rsp_data_out, .rsp_last_out, .busy_out, .cmd_error_out(), .stat_in,
      .set_button_in, .cfg_we_in, .cfg_addr_in, .cfg_data_in, .in_data_in, .nv_restore_in,
      .nv_host_in, .nv_ctrl_in, .nv_store_out(), .nv_host_out, .nv_ctrl_out,
      .data_exchange_out, .force_offline_out, .auto_addr_disable_out, .prog_run_out,
      .prog_reload_out(), .user_mem_clear_out(), .counter_map_out);
   fms_host_model u_host (.clk_in, .rsp_valid_out, .rsp_data_out, .busy_out, .cmd_valid_in,
      .cmd_code_in, .cmd_data_in);
   // ****************
   // Helpers
   // ****************
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Sends one message and compares the whole reply with the queued bytes.
   task automatic xfer(input logic [7:0] code, input logic [7:0] data);
      int i;
      u_host.rx_q.delete();
      u_host.send(code, data);
      for (i = 0; i < 100 && u_host.rx_q.size() < exp_q.size(); i++) @(posedge clk_in);
      repeat (3) @(negedge clk_in);
      check8("reply length", exp_q.size(), u_host.rx_q.size());
      foreach (exp_q[j]) check8("reply byte", exp_q[j], u_host.rx_q[j]);
      exp_q.delete();
   endtask
   // Expected version character; bit set in the mask means upper case.
   function automatic logic [7:0] vchar(input int i);
      string       s;
      logic [16:0] up;
      s  = "DBFEDC2 DOA A WT";
      up = {2'h3, stat_in.watchdog_active, 3'h7, h[2:0], 7'h7F, run};
      up[15] = stat_in.panel_enabled;
      if (i == 16) return `FMS_CHAR_NULL;
      return up[i] ? s[i] : s[i] | `FMS_CASE_LOWER;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Clock of 40 ns and watchdog on the whole run.
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      #(40 * 8000);
      fail_count++;
      final_report;
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      {fail_count, check_count, seed} = {32'h0, 32'h0, 32'd10507};
      {rst_in, set_button_in, cfg_we_in, nv_restore_in} = 4'h8;
      {stat_in, cfg_data_in, cfg_addr_in, in_data_in, h, c} = '0;
      {nv_host_in, nv_ctrl_in} = 7'h00;
      repeat (5) @(posedge clk_in);
      @(negedge clk_in) rst_in = 1'b0;
      for (n = 0; n < 8; n++) begin
         stat_in = 13'($random(seed));
         in_data_in = {8{$random(seed)}};
         {cfg_addr_in, cfg_data_in} = 22'($random(seed));
         {h, c} = 16'($random(seed));
         {nv_host_in, nv_ctrl_in} = 7'($random(seed));
         if (n == 0) c = 8'h0B;
         if (n == 0) {stat_in.master_run_ok, stat_in.config_ok} = 2'h3;
         {cfg_we_in, nv_restore_in} = 2'h3;
         @(negedge clk_in) {cfg_we_in, nv_restore_in} = 2'h0;
         check8("restored", {3'h0, nv_host_in.auto_addr_off, nv_ctrl_in},
            {3'h0, auto_addr_disable_out, nv_ctrl_out});
         exp_q = '{{5'h0, h[2:0]}};
         xfer(`FMS_CMD_WR_HOST, h);
         check8("host outputs", {5'h0, h[2:0]},
            {5'h0, auto_addr_disable_out, force_offline_out, data_exchange_out});
         check8("stored host", {5'h0, h[2:0]}, {5'h0, nv_host_out});
         u_host.send(`FMS_CMD_WR_CTRL, c);
         repeat (6) @(negedge clk_in);
         if (n == 0) check8("waiting program", 8'h00, {7'h0, prog_run_out});
         @(negedge clk_in) set_button_in = 1'b1;
         @(negedge clk_in) set_button_in = 1'b0;
         repeat (4) @(negedge clk_in);
         run = c[0] & stat_in.master_run_ok & (c[2] | stat_in.config_ok);
         check8("program run", {6'h0, c[4], run},
            {6'h0, counter_map_out, prog_run_out});
         exp_q = '{{3'h0, c[4:2], 1'b0, c[0]}};
         xfer(`FMS_CMD_RD_CTRL, 8'h00);
         e = {<<{stat_in[12:5]}};
         exp_q = '{{5'h0, h[2:0]}};
         if (stat_in.professional_mode) exp_q = '{{5'h0, h[2:0]}, e, {7'h0, stat_in[4]}};
         xfer(`FMS_CMD_RD_DIAG, 8'h00);
         exp_q = '{cfg_data_in[7:0], cfg_data_in[15:8]};
         xfer(`FMS_CMD_RD_CFG, {2'h0, cfg_addr_in});
         for (k = 0; k < 32; k++) exp_q.push_back(in_data_in[8*k+:8]);
         xfer(`FMS_CMD_RD_INPUT, 8'h00);
         for (k = 0; k < 17; k++) exp_q.push_back(vchar(k));
         xfer(`FMS_CMD_RD_VERSION, `FMS_VERSION_SELECT);
         u_host.send(`FMS_CMD_RD_VERSION, 8'h03);
      end
      repeat (4) @(posedge clk_in);
      final_report;
   end
endmodule // testbench
